// *** core/rts_controller.sv ***
module rts_controller #(
	parameter int SETTLE = rts_pkg::SETTLE_CYCLES
) (
	// System
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// User
	input wire logic key_in,
	input wire logic fsk_mode_in,
	input wire logic data_valid_in,
	input wire logic data_bit_in,
	input wire logic data_last_in,
	output logic data_ready_out,
	output logic ext_clock_out,
	output logic busy_out,
	// Link
	rts_link_if.host link
);
	import rts_pkg::*;
	rts_host_state_t state;
	logic [31:0] wait_cnt;
	logic [2:0] clk_sync;
	logic clk_s, clk_prev;
	logic fsk;

	// Clock line into the first timer input, synchronised
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			clk_sync <= 3'h0;
			clk_s <= 1'b0;
			clk_prev <= 1'b0;
		end else begin
			clk_sync <= {clk_sync[1:0], link.clk_line}; // [R11]
			if (clk_sync[2] == clk_sync[1]) clk_s <= clk_sync[2];
			clk_prev <= clk_s;
		end
	end

	// Sequencer
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state <= RTS_H_IDLE;
			wait_cnt <= 32'h0;
			fsk <= 1'b0;
		end else begin
			case (state)
				RTS_H_IDLE: begin
					if (key_in) begin // [R13]
						fsk <= fsk_mode_in;
						wait_cnt <= 32'h0;
						state <= RTS_H_WAIT;
					end
				end
				RTS_H_WAIT: begin
					if (wait_cnt >= 32'(SETTLE - 1)) state <= RTS_H_CLOCKED; // [R4] [R5]
					else wait_cnt <= wait_cnt + 32'h1;
				end
				RTS_H_CLOCKED: begin
					// Wait for a clock edge before bit timing
					if (clk_s && !clk_prev) state <= RTS_H_SEND;
				end
				RTS_H_SEND: begin
					if (data_valid_in && data_last_in && clk_s && !clk_prev) begin
						state <= RTS_H_STOP;
					end
				end
				RTS_H_STOP: begin
					state <= RTS_H_IDLE; // [R10]
				end
				default: state <= RTS_H_IDLE;
			endcase
		end
	end

	// Link drive: bits taken on rising clock edges
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			link.tx_enable <= 1'b0;
			link.amp_on <= 1'b0;
			link.cap_switch_o <= 1'b0;
			link.cap_switch_oe_n <= 1'b1;
			data_ready_out <= 1'b0;
			ext_clock_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			data_ready_out <= 1'b0;
			busy_out <= (state != RTS_H_IDLE);
			case (state)
				RTS_H_IDLE: begin
					link.tx_enable <= key_in;
					link.amp_on <= 1'b0;
					link.cap_switch_oe_n <= 1'b1;
					ext_clock_out <= 1'b0;
				end
				RTS_H_WAIT: begin
					link.amp_on <= 1'b0; // [R5]
				end
				RTS_H_CLOCKED: begin
					ext_clock_out <= 1'b1; // [R4] [R11]
					link.amp_on <= fsk; // [R7]
				end
				RTS_H_SEND: begin
					if (data_valid_in && clk_s && !clk_prev) begin
						data_ready_out <= 1'b1;
						if (fsk) begin
							link.amp_on <= 1'b1; // [R7] [R12]
							link.cap_switch_oe_n <= data_bit_in;
						end else begin
							link.amp_on <= data_bit_in; // [R12]
						end
					end
				end
				RTS_H_STOP: begin
					link.amp_on <= 1'b0; // [R10]
					link.cap_switch_oe_n <= 1'b1;
					ext_clock_out <= 1'b0;
					link.tx_enable <= 1'b0;
				end
				default: link.amp_on <= 1'b0;
			endcase
		end
	end
endmodule : rts_controller

// *** core/rts_link_if.sv ***
interface rts_link_if;
	logic tx_enable;
	logic amp_on;
	logic clk_line;
	logic cap_switch_o;
	logic cap_switch_oe_n;
	// Open-drain switch closes when driven low
	logic cap_closed;
	assign cap_closed = ~cap_switch_oe_n & ~cap_switch_o;
	modport device (input tx_enable, input amp_on, input cap_closed, output clk_line);
	modport host (output tx_enable, output amp_on, output cap_switch_o,
		output cap_switch_oe_n, input clk_line);
endinterface : rts_link_if

// *** core/rts_pkg.sv ***
package rts_pkg;
	// Settle time from enable to stable clock
	localparam int SETTLE_TIME_US = 3000;
	localparam int CLK_RATE_MHZ = 100;
	localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_RATE_MHZ;
	// Loop multiplies the oscillator by this factor
	localparam int LOOP_MULT = 32;
	// Clock output is the crystal rate divided by this
	localparam int CLKOUT_DIV = 4;
	// Oscillator tick divider from the system clock
	localparam int OSC_DIV = 2;
	// Frequency codes for the keyed carrier
	localparam logic [1:0] FREQ_NONE = 2'h0;
	localparam logic [1:0] FREQ_HIGH = 2'h1;
	localparam logic [1:0] FREQ_LOW = 2'h2;
	typedef enum logic [1:0] {RTS_STANDBY, RTS_CLOCK_ONLY, RTS_TRANSMIT} rts_state_t;
	typedef enum logic [2:0] {RTS_H_IDLE, RTS_H_WAIT, RTS_H_CLOCKED, RTS_H_SEND,
		RTS_H_STOP} rts_host_state_t;
endpackage : rts_pkg

// *** core/rts_transmitter.sv ***
// Contract
// R1 - Both enables low keeps everything off
// R2 - Enable alone runs oscillator, loop, clock
// R3 - Lock and clock stable within 3ms
// R4 - Host waits 3ms before using clock
// R5 - Host keeps amplifier off 3ms after enable
// R6 - Amplifier follows amp_on while enabled
// R7 - Host keys frequency via open-drain switch
// R8 - Closed switch gives lower frequency
// R9 - Loop locks at 32 times oscillator
// R10 - Host drops amp_on, then tx_enable; the controller drops both in the same cycle in RTS_H_STOP
// R11 - Host feeds clock into first timer input
// R12 - Two-wire for amplitude, three-wire frequency
// R13 - Host wakes on internal oscillator first
// R14 - Clock output is crystal over four
// R15 - amp_on alone never starts transmitter
module rts_transmitter #(
	parameter int SETTLE = rts_pkg::SETTLE_CYCLES
) (
	// System
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Link
	rts_link_if.device link,
	// Status
	output logic osc_on_out,
	output logic locked_out,
	output logic amp_active_out,
	output logic [1:0] freq_code_out,
	output logic [7:0] loop_mult_out
);
	import rts_pkg::*;
	rts_state_t state;
	rts_state_t next_state;
	logic [2:0] en_sync;
	logic [2:0] amp_sync;
	logic [2:0] cap_sync;
	logic en_s;
	logic amp_s;
	logic cap_s;
	logic [31:0] settle_cnt;
	logic settle_done;
	logic osc_tick;
	logic [7:0] osc_cnt;
	logic [7:0] div_cnt;
	logic clk_q;

	// Agreement filter: a new level counts once the last two stages match
	function automatic logic filt_bit(input logic [2:0] chain, input logic held);
		logic result;
		if (chain[2] == chain[1]) result = chain[2];
		else result = held;
		return result;
	endfunction : filt_bit

	// Enable pin: three stages, then the agreement filter
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			en_sync <= 3'h0;
			en_s <= 1'b0;
		end else begin
			en_sync <= {en_sync[1:0], link.tx_enable};
			en_s <= filt_bit(en_sync, en_s);
		end
	end

	// Amplifier enable pin: same filter, so a one-cycle glitch never keys the carrier
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			amp_sync <= 3'h0;
			amp_s <= 1'b0;
		end else begin
			amp_sync <= {amp_sync[1:0], link.amp_on};
			amp_s <= filt_bit(amp_sync, amp_s);
		end
	end

	// Crystal-load switch state, seen through the same filter
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cap_sync <= 3'h0;
			cap_s <= 1'b0;
		end else begin
			cap_sync <= {cap_sync[1:0], link.cap_closed};
			cap_s <= filt_bit(cap_sync, cap_s);
		end
	end

	// Power state register
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state <= RTS_STANDBY;
		end else begin
			state <= next_state;
		end
	end

	// Next power state from the filtered pins
	always_comb begin
		next_state = state;
		case (state)
			RTS_STANDBY: begin
				// Amplifier enable alone never leaves standby
				if (en_s && amp_s) next_state = RTS_TRANSMIT; // [R6] [R15]
				else if (en_s) next_state = RTS_CLOCK_ONLY; // [R2]
			end
			RTS_CLOCK_ONLY: begin
				if (!en_s) next_state = RTS_STANDBY; // [R1]
				else if (amp_s) next_state = RTS_TRANSMIT; // [R6]
			end
			RTS_TRANSMIT: begin
				if (!en_s) next_state = RTS_STANDBY; // [R1] [R15]
				else if (!amp_s) next_state = RTS_CLOCK_ONLY; // [R6]
			end
			default: next_state = RTS_STANDBY;
		endcase
	end

	// Settle counter from the filtered enable rise, stops at the end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !en_s) begin
			settle_cnt <= 32'h0;
		end else if (!settle_done) begin
			settle_cnt <= settle_cnt + 32'h1;
		end
	end

	// Loop counts as locked once the settle count has run out
	assign settle_done = (settle_cnt >= 32'(SETTLE - 1));
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !en_s) begin
			locked_out <= 1'b0;
		end else if (settle_done) begin
			locked_out <= 1'b1; // [R3]
		end
	end

	// Oscillator model tick, runs only while enabled
	// Stands in for the crystal oscillator at half the system rate
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !en_s) begin
			osc_cnt <= 8'h0;
			osc_tick <= 1'b0;
		end else if (osc_cnt == 8'(OSC_DIV - 1)) begin
			osc_cnt <= 8'h0;
			osc_tick <= 1'b1;
		end else begin
			osc_cnt <= osc_cnt + 8'h1;
			osc_tick <= 1'b0;
		end
	end

	// Clock output: one period per CLKOUT_DIV oscillator ticks
	// Held low whenever the enable is down, so standby shows no clock
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !en_s) begin
			div_cnt <= 8'h0;
			clk_q <= 1'b0; // [R1]
		end else if (osc_tick) begin
			if (div_cnt == 8'(CLKOUT_DIV / 2 - 1)) begin
				div_cnt <= 8'h0;
				clk_q <= ~clk_q; // [R14] [R2]
			end else begin
				div_cnt <= div_cnt + 8'h1;
			end
		end
	end
	assign link.clk_line = clk_q;

	// Oscillator, loop and clock driver running flag
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			osc_on_out <= 1'b0;
		end else begin
			osc_on_out <= en_s; // [R2] [R1]
		end
	end

	// Amplifier on only in the transmit state
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			amp_active_out <= 1'b0;
		end else begin
			amp_active_out <= (next_state == RTS_TRANSMIT); // [R6] [R15]
		end
	end

	// Loop multiplier report, zero while the loop is off
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			loop_mult_out <= 8'h0;
		end else begin
			loop_mult_out <= en_s ? 8'(LOOP_MULT) : 8'h0; // [R9]
		end
	end

	// Carrier frequency from the crystal-load switch
	// Switch closed adds load capacitance and pulls the carrier down
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			freq_code_out <= FREQ_NONE;
		end else if (next_state != RTS_TRANSMIT) begin
			freq_code_out <= FREQ_NONE;
		end else if (cap_s) begin
			freq_code_out <= FREQ_LOW; // [R8]
		end else begin
			freq_code_out <= FREQ_HIGH; // [R8]
		end
	end
endmodule : rts_transmitter

// *** tb/rts_link_props.sv ***
module rts_link_props #(
	parameter int SETTLE = rts_pkg::SETTLE_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic tx_enable,
	input wire logic amp_on,
	input wire logic clk_line,
	input wire logic cap_switch_o,
	input wire logic cap_switch_oe_n,
	input wire logic cap_closed
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_cnt;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// Cycles the enable has stood high
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !tx_enable)
			wait_cnt <= 0;
		else if (wait_cnt < SETTLE)
			wait_cnt <= wait_cnt + 1;
	end
	sequence s_wake;
		$rose(tx_enable) ##1 tx_enable;
	endsequence
	sequence s_high_half;
		clk_line [*4] ##1 !clk_line;
	endsequence
	sequence s_low_half;
		!clk_line [*4] ##1 clk_line;
	endsequence
	a_amp_settle: assert property (amp_on |-> wait_cnt >= SETTLE)
		else $error("amplifier enabled before settle");
	a_amp_needs_en: assert property (amp_on |-> tx_enable)
		else $error("amplifier on without enable");
	a_en_holds: assert property (s_wake |-> tx_enable [*8])
		else $error("enable dropped during settle");
	a_clk_idle: assert property (!tx_enable [*8] |-> !clk_line)
		else $error("clock line runs in standby");
	a_clk_high: assert property (@(posedge ref_clk_in) disable iff (rst_in || !tx_enable)
		$rose(clk_line) |-> s_high_half)
		else $error("clock high half wrong");
	a_clk_low: assert property (@(posedge ref_clk_in) disable iff (rst_in || !tx_enable)
		$fell(clk_line) |-> s_low_half)
		else $error("clock low half wrong");
	a_clk_runs: assert property (@(posedge ref_clk_in) disable iff (rst_in || !tx_enable)
		wait_cnt >= 8 |-> ##[0:4] $changed(clk_line))
		else $error("clock line stuck while enabled");
	a_fsk_keyed: assert property ($changed(cap_switch_oe_n) |-> amp_on || $past(amp_on))
		else $error("switch keyed with amplifier off");
endmodule : rts_link_props

// *** tb/test_rf_tx_enable_sequencer.sv ***
module test_rf_tx_enable_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import rts_pkg::*;
	localparam int ST = 20;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic key_in = 1'b0;
	logic fsk = 1'b0;
	logic dv = 1'b0;
	logic db = 1'b0;
	logic dl = 1'b0;
	logic osc, lock, amp, rdy, ext, busy, bad_osc, bad_amp;
	logic [1:0] fq;
	logic [7:0] mult;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	rts_link_if link();
	rts_link_if bad_link();
	rts_transmitter #(.SETTLE(ST)) rts_transmitter_inst (.ref_clk_in, .rst_in,
		.link(link.device), .osc_on_out(osc), .locked_out(lock), .amp_active_out(amp),
		.freq_code_out(fq), .loop_mult_out(mult));
	rts_controller #(.SETTLE(ST)) rts_controller_inst (.ref_clk_in, .rst_in, .key_in,
		.fsk_mode_in(fsk), .data_valid_in(dv), .data_bit_in(db), .data_last_in(dl),
		.data_ready_out(rdy), .ext_clock_out(ext), .busy_out(busy), .link(link.host));
	// Faulty host: amplifier raised with the enable low
	assign bad_link.tx_enable = 1'b0;
	assign bad_link.amp_on = 1'b1;
	assign bad_link.cap_switch_o = 1'b1;
	assign bad_link.cap_switch_oe_n = 1'b1;
	rts_transmitter #(.SETTLE(ST)) rts_transmitter_inst2 (.ref_clk_in, .rst_in,
		.link(bad_link.device), .osc_on_out(bad_osc), .locked_out(), .amp_active_out(bad_amp),
		.freq_code_out(), .loop_mult_out());
	rts_link_props #(.SETTLE(ST)) rts_link_props_inst (.ref_clk_in, .rst_in,
		.tx_enable(link.tx_enable), .amp_on(link.amp_on), .clk_line(link.clk_line),
		.cap_switch_o(link.cap_switch_o), .cap_switch_oe_n(link.cap_switch_oe_n),
		.cap_closed(link.cap_closed));
	always #5 ref_clk_in = ~ref_clk_in;
	// Hang guard
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			wrap_up();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task wrap_up;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// One wake, settle, four keyed bits and return to standby
	task frame(input logic mode, input logic [3:0] bits);
		int t;
		@(negedge ref_clk_in);
		fsk = mode;
		key_in = 1'b1;
		@(negedge ref_clk_in);
		key_in = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		check(osc, 8'h1);
		check(amp, 8'h0);
		check(mult, 8'(LOOP_MULT));
		check(lock, 8'h0);
		t = 7;
		while (ext !== 1'b1 && t < 200) begin
			@(negedge ref_clk_in);
			t++;
		end
		check(t > ST, 8'h1);
		for (int i = 3; i >= 0; i--) begin
			dv = 1'b1;
			db = bits[i];
			dl = (i == 0);
			t = 0;
			while (rdy !== 1'b1 && t < 50) begin
				@(negedge ref_clk_in);
				t++;
			end
			dv = 1'b0;
			if (i > 0) begin
				repeat (6) @(negedge ref_clk_in);
				check(lock, 8'h1);
				if (mode) begin
					check(amp, 8'h1);
					check(fq, bits[i] ? FREQ_HIGH : FREQ_LOW);
				end else
					check(amp, bits[i]);
			end
		end
		t = 0;
		while (busy !== 1'b0 && t < 50) begin
			@(negedge ref_clk_in);
			t++;
		end
		repeat (10) @(negedge ref_clk_in);
		check(osc, 8'h0);
		check(amp, 8'h0);
		check(mult, 8'h0);
		check(fq, FREQ_NONE);
		check(ext, 8'h0);
	endtask : frame
	// Main sequence
	initial begin
		repeat (10) @(negedge ref_clk_in);
		rst_in = 1'b0;
		frame(1'b0, 4'ha);
		frame(1'b1, 4'h5);
		check(bad_osc, 8'h0);
		check(bad_amp, 8'h0);
		wrap_up();
	end
endmodule : test_rf_tx_enable_sequencer
